// ===== shared/ptk_defs.svh
// Constants shared by both ends of the elapsed-time tracker link
`ifndef PTK_DEFS_SVH
`define PTK_DEFS_SVH
// Timing
`define PTK_MCLK_NS    5
`define PTK_SEC_NS     1000000000
`define PTK_SEC_CYC    (`PTK_SEC_NS / `PTK_MCLK_NS)
`define PTK_HALF_NS    40
`define PTK_HALF_CYC   (`PTK_HALF_NS / `PTK_MCLK_NS)
`define PTK_SVC_SEC    86400
// Frame: 8 command bits then 32 data bits, LSB first
`define PTK_CMD_RD     0
`define PTK_CMD_SEL    1
`define PTK_CMD_BITS   6'h08
`define PTK_LAST_BIT   6'h27
`define PTK_TAIL       6'h28
// Counter fields
`define PTK_OVF        24
`define PTK_YRS        27:25
`define PTK_YRS_MAX    3'h7
`define PTK_PCH        31:28
`define PTK_PCH_MAX    4'hF
`define PTK_PUC        31:25
`define PTK_PUC_MAX    7'h7F
`define PTK_LOW        23:0
`define PTK_MEM_CLR    8'h00
// Controller register byte offsets
`define PTK_A_CTRL     8'h00
`define PTK_A_STAT     8'h04
`define PTK_A_WDATA    8'h08
`define PTK_A_RDATA    8'h0C
`define PTK_A_SAVE     8'h10
`define PTK_A_IRQ_ST   8'h14
`define PTK_A_IRQ_EN   8'h18
`define PTK_A_IRQ_CLR  8'h1C
`define PTK_A_AUTO     8'h20
`define PTK_CTRL_OP    2:0
// Interrupt bits
`define PTK_IRQ_W      4
`define PTK_IRQ_DONE   0
`define PTK_IRQ_CONT   1
`define PTK_IRQ_PWR    2
`define PTK_IRQ_WRAP   3
// Operation codes
`define PTK_OP_RDC     3'h0
`define PTK_OP_RDP     3'h1
`define PTK_OP_WRC     3'h2
`define PTK_OP_WRP     3'h3
`define PTK_OP_INIT    3'h4
`define PTK_OP_PU      3'h5
`define PTK_OP_SVC     3'h6
// Pin synchroniser reset pattern {pwr, dq, sclk, ce}
`define PTK_SYNC_RST   4'h4
`endif

// ===== shared/ptk_pkg.sv
// Types shared by the tracker device and its controller
package ptk_pkg;
`include "ptk_defs.svh"
   typedef logic [31:0] ptk_word_t;
   typedef enum logic [2:0] {
      OP_RD_C = `PTK_OP_RDC,
      OP_RD_P = `PTK_OP_RDP,
      OP_WR_C = `PTK_OP_WRC,
      OP_WR_P = `PTK_OP_WRP,
      OP_INIT = `PTK_OP_INIT,
      OP_PU   = `PTK_OP_PU,
      OP_SVC  = `PTK_OP_SVC
   } ptk_op_t;
   typedef enum logic [5:0] {
      SQ_IDLE = 6'h01,
      SQ_RD1  = 6'h02,
      SQ_WR1  = 6'h04,
      SQ_RD2  = 6'h08,
      SQ_WR2  = 6'h10,
      SQ_FIN  = 6'h20
   } ptk_seq_t;
endpackage

// ===== shared/ptk_if.sv
// Three-wire link between controller and tracker device
`timescale 1ns/1ps
interface ptk_if;
   logic ce;
   logic sclk;
   logic h_dq_o;
   logic h_dq_oe;
   logic d_dq_o;
   logic d_dq_oe;
   logic dq;
   // Wire level: host drive, else device drive, else pull-up
   assign dq = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : 1'b1);
   modport host (output ce, output sclk, output h_dq_o, output h_dq_oe,
                 input dq);
   modport dev  (input ce, input sclk, input dq, output d_dq_o,
                 output d_dq_oe);
endinterface

// ===== verilog/ptk_device.sv
// Tracker device: two seconds counters behind the three-wire link
`timescale 1ns/1ps
`include "ptk_defs.svh"
module ptk_device
   import ptk_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `PTK_SEC_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic pwr_good,
   ptk_if.dev       link
);
   logic [3:0] s1, s2, s3, flt;
   logic       sclk_q, rise, fall, ce, dq, pwr_on;
   logic [31:0] tcnt;
   logic        tick;
   ptk_word_t   continuous_seconds_count;
   ptk_word_t   powered_seconds_count;
   logic [5:0]  cnt;
   logic [7:0]  cmd;
   ptk_word_t   wsh, snap, wr_val;
   logic        wr_go;

   // Pins: three flops, a change counts once stages two and three agree
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s1  <= `PTK_SYNC_RST;
         s2  <= `PTK_SYNC_RST;
         s3  <= `PTK_SYNC_RST;
         flt <= `PTK_SYNC_RST;
      end else begin
         s1  <= {pwr_good, link.dq, link.sclk, link.ce};
         s2  <= s1;
         s3  <= s2;
         flt <= (s2 & ~(s2 ^ s3)) | (flt & (s2 ^ s3));
      end
   end
   assign ce     = flt[0];
   assign dq     = flt[2];
   assign pwr_on = flt[3];

   // Edge finder on the filtered link clock
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) sclk_q <= 1'b0;
      else       sclk_q <= flt[1];
   end
   assign rise = flt[1] & ~sclk_q;
   assign fall = ~flt[1] & sclk_q;

   // One-second timebase enable
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tcnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (tcnt == SEC_CYCLES - 1);
         tcnt <= (tcnt == SEC_CYCLES - 1) ? '0 : tcnt + 32'h1;
      end
   end

   // Frame shifter: command byte, then write data on rising edges
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
         cmd <= '0;
         wsh <= '0;
      end else if (!ce) begin
         cnt <= '0;
      end else if (rise && cnt != `PTK_TAIL) begin
         cnt <= cnt + 6'h01;
         if (cnt < `PTK_CMD_BITS) cmd <= {dq, cmd[7:1]};
         else if (!cmd[`PTK_CMD_RD]) wsh <= {dq, wsh[31:1]};
      end
   end
   // Last data bit completes the word in the same cycle it commits
   assign wr_go  = ce & rise & (cnt == `PTK_LAST_BIT) & ~cmd[`PTK_CMD_RD];
   assign wr_val = {dq, wsh[31:1]};

   // Read drive on falling edges; whole word captured at once
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         snap         <= '0;
         link.d_dq_o  <= 1'b1;
         link.d_dq_oe <= 1'b0;
      end else if (!ce || !cmd[`PTK_CMD_RD]) begin
         link.d_dq_oe <= 1'b0;
      end else if (fall && cnt == `PTK_CMD_BITS) begin
         // Snapshot keeps a tick from tearing the word
         snap         <= (cmd[`PTK_CMD_SEL] ? powered_seconds_count
                                            : continuous_seconds_count) >> 1;
         link.d_dq_o  <= cmd[`PTK_CMD_SEL] ? powered_seconds_count[0]
                                           : continuous_seconds_count[0];
         link.d_dq_oe <= 1'b1;
      end else if (fall && cnt > `PTK_CMD_BITS) begin
         snap         <= snap >> 1;
         link.d_dq_o  <= snap[0];
         link.d_dq_oe <= (cnt != `PTK_TAIL);
      end
   end

   // Continuous count: every tick, power or not
   // Plain carry sets the overflow bit on low-field wrap
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) continuous_seconds_count <= '0;
      else if (wr_go && !cmd[`PTK_CMD_SEL])
         continuous_seconds_count <= wr_val;
      else if (tick)
         continuous_seconds_count <= continuous_seconds_count + 32'h1;
   end

   // Powered count: only while primary power is present
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) powered_seconds_count <= '0;
      else if (wr_go && cmd[`PTK_CMD_SEL])
         powered_seconds_count <= wr_val;
      else if (tick && pwr_on)
         powered_seconds_count <= powered_seconds_count + 32'h1;
   end
endmodule

// ===== verilog/ptk_host.sv
// Controller: keeps the tracker counters serviced, APB command port
// Function
// - Two 32-bit second counters, host read/write
// - Low 24 continuous bits are live seconds
// - Bit 25 set when low field wraps
// - Continuous bits 26-28 count half-years
// - Bits 29-32 count 128 power cycles
// - Low 24 powered bits hold powered seconds
// - Powered bits 26-32 count power-ups
// - Service the device at least yearly
// - Overflow set: clear, bump half-year count
// - Half-year count stops at seven
// - Powered overflow: clear and save value
// - Device keeps two powered half-years at most
// - First write clears powered bits 25-32
// - Power-up: bump seven-bit count below max
// - At max: zero it, bump high four
// - Fields together record 2047 power cycles
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ptk_defs.svh"
module ptk_host
   import ptk_pkg::*;
#(
   parameter int unsigned SEC_CYCLES  = `PTK_SEC_CYC,
   parameter int unsigned SVC_SECONDS = `PTK_SVC_SEC
) (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   output      logic        irq,
   ptk_if.host              link
);
   ptk_seq_t  sq;
   ptk_op_t   op, cmd_op;
   ptk_word_t wdata, rdata, save, xwd, rx, rd_mux;
   logic [39:0] sh;
   logic [`PTK_IRQ_W-1:0] irq_stat, irq_en, ev, clr;
   logic [2:0]  dsync;
   logic        dq_s, go, pend_pu, more, auto_en, due;
   logic        xreq, xrd, xsel, xdone, lbusy, lrd;
   logic        take_pu, take_go, take_svc, apb_wr;
   logic [5:0]  bitn;
   logic [7:0]  hcnt;
   logic [31:0] tcnt, scnt;

   function automatic logic ptk_hit(input logic [7:0] a);
      ptk_hit = (a <= `PTK_A_AUTO) && (a[1:0] == 2'h0);
   endfunction
   function automatic ptk_word_t ptk_clr_ovf(input ptk_word_t w);
      ptk_clr_ovf = w;
      ptk_clr_ovf[`PTK_OVF] = 1'b0;
   endfunction

   assign take_pu  = (sq == SQ_IDLE) & pend_pu;
   assign take_go  = (sq == SQ_IDLE) & ~pend_pu & go;
   assign take_svc = (sq == SQ_IDLE) & ~pend_pu & ~go & due & auto_en;
   assign xrd      = (sq == SQ_RD1) | (sq == SQ_RD2);
   assign apb_wr   = psel & penable & pready & pwrite;
   assign clr      = (apb_wr && paddr == `PTK_A_IRQ_CLR)
                     ? pwdata[`PTK_IRQ_W-1:0] : '0;

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_mux = '0;
      case (paddr)
         `PTK_A_CTRL:   rd_mux[`PTK_CTRL_OP] = cmd_op;
         `PTK_A_STAT:   rd_mux[3:0] = {due, pend_pu, go, sq != SQ_IDLE};
         `PTK_A_WDATA:  rd_mux = wdata;
         `PTK_A_RDATA:  rd_mux = rdata;
         `PTK_A_SAVE:   rd_mux = save;
         `PTK_A_IRQ_ST: rd_mux[`PTK_IRQ_W-1:0] = irq_stat;
         `PTK_A_IRQ_EN: rd_mux[`PTK_IRQ_W-1:0] = irq_en;
         `PTK_A_AUTO:   rd_mux[0] = auto_en;
         default:       rd_mux = '0;
      endcase
   end

   // APB slave: one wait state, writes land on the completing edge
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
         go      <= 1'b0;
         cmd_op  <= OP_RD_C;
         wdata   <= '0;
         irq_en  <= '0;
         auto_en <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~ptk_hit(paddr);
         if (psel && penable && !pready) prdata <= rd_mux;
         // A new command written as the old one is taken stays pending
         if (take_go) go <= 1'b0;
         if (apb_wr) begin
            case (paddr)
               `PTK_A_CTRL: begin
                  go     <= 1'b1;
                  cmd_op <= ptk_op_t'(pwdata[`PTK_CTRL_OP]);
               end
               `PTK_A_WDATA:  wdata   <= pwdata;
               `PTK_A_IRQ_EN: irq_en  <= pwdata[`PTK_IRQ_W-1:0];
               `PTK_A_AUTO:   auto_en <= pwdata[0];
               default: ;
            endcase
         end
      end
   end

   // Sticky events, set beats clear; level interrupt
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_stat <= '0;
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~clr) | ev;
         irq      <= |(irq_stat & irq_en);
      end
   end

   // Service timer: raises a request well inside a year
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tcnt <= '0;
         scnt <= '0;
         due  <= 1'b0;
      end else begin
         tcnt <= (tcnt == SEC_CYCLES - 1) ? '0 : tcnt + 32'h1;
         if (tcnt == SEC_CYCLES - 1)
            scnt <= (scnt == SVC_SECONDS - 1) ? '0 : scnt + 32'h1;
         if (tcnt == SEC_CYCLES - 1 && scnt == SVC_SECONDS - 1) due <= 1'b1;
         else if (take_svc) due <= 1'b0;
      end
   end

   // Sequencer; read-modify-write may drop a tick that lands mid-frame
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sq      <= SQ_IDLE;
         op      <= OP_PU;
         pend_pu <= 1'b1;
         more    <= 1'b0;
         xreq    <= 1'b0;
         xsel    <= 1'b0;
         xwd     <= '0;
         rdata   <= '0;
         save    <= '0;
         ev      <= '0;
      end else begin
         xreq <= 1'b0;
         ev   <= '0;
         case (sq)
            SQ_IDLE: begin
               xwd  <= wdata;
               more <= 1'b0;
               if (take_pu) begin
                  // Reset release counts as a power-up
                  pend_pu <= 1'b0;
                  op      <= OP_PU;
                  xsel    <= 1'b1;
                  xreq    <= 1'b1;
                  sq      <= SQ_RD1;
               end else if (take_go || take_svc) begin
                  op   <= take_svc ? OP_SVC : cmd_op;
                  // A commanded power-up starts on the powered counter
                  xsel <= take_go & (cmd_op == OP_RD_P || cmd_op == OP_WR_P
                                     || cmd_op == OP_INIT
                                     || cmd_op == OP_PU);
                  xreq <= 1'b1;
                  if (take_go && cmd_op == OP_INIT)
                     xwd <= {`PTK_MEM_CLR, wdata[`PTK_LOW]};
                  if (take_go && (cmd_op == OP_WR_C || cmd_op == OP_WR_P
                                  || cmd_op == OP_INIT))
                     sq <= SQ_WR1;
                  else
                     sq <= SQ_RD1;
               end
            end
            SQ_RD1: if (xdone) begin
               rdata <= rx;
               xwd   <= rx;
               case (op)
                  OP_PU: begin
                     xreq <= 1'b1;
                     sq   <= SQ_WR1;
                     if (rx[`PTK_PUC] != `PTK_PUC_MAX) begin
                        xwd[`PTK_PUC] <= rx[`PTK_PUC] + 7'h01;
                     end else begin
                        xwd[`PTK_PUC] <= '0;
                        more          <= 1'b1;
                        ev[`PTK_IRQ_WRAP] <= 1'b1;
                     end
                  end
                  OP_SVC: begin
                     xreq <= 1'b1;
                     // Full half-year count: leave it at seven, overflow bit set
                     if (rx[`PTK_OVF] && rx[`PTK_YRS] != `PTK_YRS_MAX) begin
                        xwd <= ptk_clr_ovf(rx);
                        xwd[`PTK_YRS] <= rx[`PTK_YRS] + 3'h1;
                        more <= 1'b1;
                        ev[`PTK_IRQ_CONT] <= 1'b1;
                        sq   <= SQ_WR1;
                     end else begin
                        xsel <= 1'b1;
                        sq   <= SQ_RD2;
                     end
                  end
                  default: sq <= SQ_FIN;
               endcase
            end
            SQ_WR1: if (xdone) begin
               if (more) begin
                  xsel <= (op == OP_SVC);
                  xreq <= 1'b1;
                  sq   <= SQ_RD2;
               end else begin
                  sq <= SQ_FIN;
               end
            end
            SQ_RD2: if (xdone) begin
               xwd <= rx;
               if (op == OP_PU) begin
                  // High four saturate: 15 x 128 + 127 cycles
                  if (rx[`PTK_PCH] != `PTK_PCH_MAX)
                     xwd[`PTK_PCH] <= rx[`PTK_PCH] + 4'h1;
                  xreq <= 1'b1;
                  sq   <= SQ_WR2;
               end else if (rx[`PTK_OVF]) begin
                  save <= rx;
                  xwd  <= ptk_clr_ovf(rx);
                  ev[`PTK_IRQ_PWR] <= 1'b1;
                  xreq <= 1'b1;
                  sq   <= SQ_WR2;
               end else begin
                  sq <= SQ_FIN;
               end
            end
            SQ_WR2: if (xdone) sq <= SQ_FIN;
            SQ_FIN: begin
               ev[`PTK_IRQ_DONE] <= 1'b1;
               sq <= SQ_IDLE;
            end
            default: sq <= SQ_IDLE;
         endcase
      end
   end

   // Data pin synchroniser: change counts when stages two and three agree
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dsync <= 3'h7;
         dq_s  <= 1'b1;
      end else begin
         dsync <= {dsync[1:0], link.dq};
         if (dsync[1] == dsync[2]) dq_s <= dsync[2];
      end
   end

   // Link engine: host makes the clock; device samples on rising edges
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lbusy        <= 1'b0;
         lrd          <= 1'b0;
         xdone        <= 1'b0;
         bitn         <= '0;
         hcnt         <= '0;
         sh           <= '0;
         rx           <= '0;
         link.ce      <= 1'b0;
         link.sclk    <= 1'b0;
         link.h_dq_o  <= 1'b1;
         link.h_dq_oe <= 1'b0;
      end else begin
         xdone <= 1'b0;
         if (!lbusy) begin
            if (xreq) begin
               lbusy        <= 1'b1;
               lrd          <= xrd;
               bitn         <= '0;
               hcnt         <= '0;
               sh           <= {xwd, 6'h00, xsel, xrd};
               link.ce      <= 1'b1;
               link.h_dq_o  <= xrd;
               link.h_dq_oe <= 1'b1;
            end
         end else if (hcnt != 8'(`PTK_HALF_CYC - 1)) begin
            hcnt <= hcnt + 8'h01;
         end else begin
            hcnt <= '0;
            if (bitn == `PTK_TAIL) begin
               // Idle half period lets the device see select drop
               lbusy <= 1'b0;
               xdone <= 1'b1;
            end else if (!link.sclk) begin
               link.sclk <= 1'b1;
            end else begin
               link.sclk <= 1'b0;
               if (lrd && bitn >= `PTK_CMD_BITS) rx <= {dq_s, rx[31:1]};
               if (bitn == `PTK_LAST_BIT) begin
                  link.ce      <= 1'b0;
                  link.h_dq_oe <= 1'b0;
                  bitn         <= `PTK_TAIL;
               end else begin
                  bitn         <= bitn + 6'h01;
                  sh           <= sh >> 1;
                  link.h_dq_o  <= sh[1];
                  link.h_dq_oe <= ~(lrd && bitn >= `PTK_CMD_BITS - 6'h01);
               end
            end
         end
      end
   end
endmodule

// ===== tb/ptk_monitor.sv
// Checker on the three-wire link between controller and device
`timescale 1ns/1ps
module ptk_monitor (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic sclk,
   input wire logic h_dq_o,
   input wire logic h_dq_oe,
   input wire logic d_dq_o,
   input wire logic d_dq_oe,
   input wire logic dq
);
   logic       sclk_q;
   logic [5:0] n_rise;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Count link clock rises per frame; a short frame must never occur
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         n_rise <= 6'h00;
      end else begin
         sclk_q <= sclk;
         if (!ce) begin
            n_rise <= 6'h00;
         end else if (sclk && !sclk_q) begin
            n_rise <= n_rise + 6'h01;
         end
      end
   end
   property p_no_clash; d_dq_oe |-> !h_dq_oe && dq == d_dq_o; endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drive the data line");
   property p_sclk_idle; !ce |-> !sclk; endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("link clock moves outside a frame");
   property p_first_rise;
      $rose(ce) |-> (h_dq_oe && !sclk) ##1 !sclk [*7] ##1 sclk;
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("frame start timing wrong");
   property p_high; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
   a_high: assert property (p_high)
      else $error("link clock high phase not 8 cycles");
   property p_low; $fell(sclk) |-> !sclk [*8]; endproperty
   a_low: assert property (p_low)
      else $error("link clock low phase short");
   property p_gap; $fell(ce) |-> !ce [*8]; endproperty
   a_gap: assert property (p_gap)
      else $error("frames too close");
   property p_frame; $fell(ce) |-> n_rise == 6'h28; endproperty
   a_frame: assert property (p_frame)
      else $error("frame is not 40 bits");
   property p_hold; h_dq_oe && sclk && $past(sclk) |-> $stable(h_dq_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("host data changed while clock high");
   property p_turn; $rose(d_dq_oe) |-> !$past(h_dq_oe); endproperty
   a_turn: assert property (p_turn)
      else $error("device took the line before host let go");
   property p_release; $fell(ce) |-> ##[1:8] !d_dq_oe; endproperty
   a_release: assert property (p_release)
      else $error("device still drives after frame");
endmodule

// ===== tb/power_cycle_elapsed_tracker_bench.sv
// Bench joining controller and device, driving APB and power good
`timescale 1ns/1ps
`include "ptk_defs.svh"
module power_cycle_elapsed_tracker_bench
   import ptk_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rstn, pwr_good, psel, penable, pwrite, pready, pslverr;
   logic        irq, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv, e;
   int          n_mismatch, tests_run, seed, i;
   logic [10:0] pe;
   ptk_word_t   w;
   ptk_word_t   ws [2];
   ptk_if lk();
   ptk_host #(.SEC_CYCLES(64), .SVC_SECONDS(3)) u_ptk_host (
      .mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .link(lk));
   ptk_device #(.SEC_CYCLES(64)) u_ptk_device (
      .mclk(mclk), .rstn(rstn), .pwr_good(pwr_good), .link(lk));
   ptk_monitor u_ptk_monitor (
      .mclk(mclk), .rstn(rstn), .ce(lk.ce), .sclk(lk.sclk),
      .h_dq_o(lk.h_dq_o), .h_dq_oe(lk.h_dq_oe), .d_dq_o(lk.d_dq_o),
      .d_dq_oe(lk.d_dq_oe), .dq(lk.dq));
   always #2.5 mclk = ~mclk;
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic wen,
                      input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= wen;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll a register under a bound until masked bits reach a value
   task automatic wait_val(input logic [7:0] a, input logic [31:0] m, v);
      int n;
      n = 0;
      do begin
         apb(a, 1'b0, 32'h0);
         n++;
      end while ((rv & m) !== v && n < 1500);
      if (n >= 1500) n_mismatch++;
   endtask
   // Start an op and wait until neither busy nor pending
   task automatic op(input logic [2:0] c, input logic [31:0] d);
      apb(`PTK_A_WDATA, 1'b1, d);
      apb(`PTK_A_CTRL, 1'b1, {29'h0, c});
      wait_val(`PTK_A_STAT, 32'h3, 32'h0);
   endtask
   task automatic rdc(input logic [2:0] c);
      op(c, 32'h0);
      apb(`PTK_A_RDATA, 1'b0, 32'h0);
   endtask
   task automatic chk(input string nm, input logic [31:0] x, s);
      tests_run++;
      if (s !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
      end
   endtask
   // Counters keep running, so a read lands within a tick window
   task automatic chk_rng(input string nm, input logic [31:0] lo, s);
      tests_run++;
      if (((s - lo) <= 32'h40) !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", nm, lo, s);
      end
   endtask
   // Upper byte of the continuous counter after one service pass
   function automatic logic [31:0] svc_hi(input logic [31:0] c);
      if (c[24] && c[27:25] != 3'h7) return {c[31:28], c[27:25] + 3'h1,
                                             25'h0};
      return {c[31:24], 24'h0};
   endfunction
   // {seven-bit power-up count, high four} after a power-up pass
   function automatic logic [10:0] pu_exp(input logic [6:0] p,
                                          input logic [3:0] h);
      if (p != 7'h7F) return {p + 7'h01, h};
      return {7'h00, (h == 4'hF) ? h : h + 4'h1};
   endfunction
   task automatic test_done();
      $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog: run needs about 50k cycles, this fires at 95k
   initial begin
      #475000;
      n_mismatch++;
      test_done();
   end
   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {n_mismatch, tests_run} = '0;
      pwr_good = 1'b1;
      seed = 85454;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      chk("irq", 32'h0, 32'(irq));
      apb(8'h24, 1'b0, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("slv_rd", 32'h0, rv);
      rdc(`PTK_OP_RDP);
      chk("puc", 32'h1, 32'(rv[31:25]));
      $display("test reset done");
      for (i = 0; i < 3; i++) begin
         w = $random(seed) & 32'hFE7FFFFF;
         op(`PTK_OP_WRC, w);
         rdc(`PTK_OP_RDC);
         chk_rng("cont", w, rv);
         op(`PTK_OP_WRP, w);
         rdc(`PTK_OP_RDP);
         chk_rng("pwr", w, rv);
      end
      $display("test random rw done");
      ws[0] = 32'h34FFFFF0;
      ws[1] = 32'h0F000100;
      apb(`PTK_A_IRQ_EN, 1'b1, 32'h2);
      for (i = 0; i < 2; i++) begin
         op(`PTK_OP_WRC, ws[i]);
         repeat (2000) @(posedge mclk);
         op(`PTK_OP_SVC, 32'h0);
         rdc(`PTK_OP_RDC);
         e = svc_hi(ws[i] | 32'h01000000);
         chk("svc", e, rv & 32'hFF000000);
      end
      apb(`PTK_A_IRQ_ST, 1'b0, 32'h0);
      chk("st_cont", 32'h2, rv & 32'h2);
      chk("irq_on", 32'h1, 32'(irq));
      apb(`PTK_A_IRQ_EN, 1'b1, 32'h0);
      apb(`PTK_A_IRQ_CLR, 1'b1, 32'hF);
      op(`PTK_OP_RDC, 32'h0);
      chk("irq_mask", 32'h0, 32'(irq));
      apb(`PTK_A_IRQ_EN, 1'b1, 32'h1);
      apb(`PTK_A_IRQ_ST, 1'b0, 32'h0);
      chk("irq_done", 32'h1, 32'(irq));
      apb(`PTK_A_IRQ_CLR, 1'b1, 32'hF);
      apb(`PTK_A_IRQ_ST, 1'b0, 32'h0);
      chk("irq_clr", 32'h0, 32'(irq));
      $display("test service done");
      for (i = 0; i < 3; i++) begin
         w = {(i == 2) ? 7'h05 : 7'h7F, 25'h100};
         e = {(i == 1) ? 4'hF : 4'h2, 28'h100};
         op(`PTK_OP_WRC, e);
         op(`PTK_OP_WRP, w);
         op(`PTK_OP_PU, 32'h0);
         pe = pu_exp(w[31:25], e[31:28]);
         rdc(`PTK_OP_RDP);
         chk("puc", 32'(pe[10:4]), 32'(rv[31:25]));
         rdc(`PTK_OP_RDC);
         chk("pch", 32'(pe[3:0]), 32'(rv[31:28]));
      end
      apb(`PTK_A_IRQ_ST, 1'b0, 32'h0);
      chk("st_wrap", 32'h8, rv & 32'h8);
      op(`PTK_OP_INIT, 32'hFFABCDEF);
      apb(`PTK_A_WDATA, 1'b0, 32'h0);
      chk("wdata", 32'hFFABCDEF, rv);
      rdc(`PTK_OP_RDP);
      chk("init_hi", 32'h0, rv & 32'hFF000000);
      chk_rng("init_lo", 32'h00ABCDEF, rv);
      op(`PTK_OP_WRP, 32'h0AFFFFF0);
      repeat (2000) @(posedge mclk);
      op(`PTK_OP_SVC, 32'h0);
      apb(`PTK_A_SAVE, 1'b0, 32'h0);
      chk("save", 32'h0B000000, rv & 32'hFF000000);
      rdc(`PTK_OP_RDP);
      chk("pwr_clr", 32'h0A000000, rv & 32'hFF000000);
      $display("test powered done");
      pwr_good <= 1'b0;
      op(`PTK_OP_WRP, 32'h100);
      op(`PTK_OP_WRC, 32'h100);
      repeat (1500) @(posedge mclk);
      rdc(`PTK_OP_RDP);
      chk("pwr_off", 32'h100, rv);
      rdc(`PTK_OP_RDC);
      chk_rng("cont_on", 32'h110, rv);
      pwr_good <= 1'b1;
      op(`PTK_OP_WRC, 32'h03000010);
      apb(`PTK_A_IRQ_CLR, 1'b1, 32'hF);
      apb(`PTK_A_AUTO, 1'b1, 32'h1);
      wait_val(`PTK_A_IRQ_ST, 32'h2, 32'h2);
      apb(`PTK_A_AUTO, 1'b1, 32'h0);
      rdc(`PTK_OP_RDC);
      chk("auto", 32'h04000000, rv & 32'hFF000000);
      $display("test auto done");
      test_done();
   end
endmodule
